// ===== bench/rsm_checker.sv
// Port-level checks for the reset sequencer
`timescale 1ns/100ps
`default_nettype none
module rsm_checker #(
  parameter int DLY_SHORT_P = 8
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Bus
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic o_wb_ack,
  // Pin and causes
  input wire logic i_rst_pin,
  input wire logic o_rst_pin,
  input wire logic o_rst_pin_oe,
  input wire logic i_supply_low,
  input wire logic i_wdg_underflow,
  input wire logic i_halt,
  // CPU side
  input wire logic o_cpu_reset,
  input wire logic o_fetch_en,
  input wire logic [15:0] o_fetch_addr,
  input wire logic o_warn_irq,
  input wire rsm_pkg::ana_ctl_t o_ana_ctl
);
  logic [15:0] oe_run; // Consecutive cycles of pin drive
  logic [15:0] next_oe_run;
  // Saturating run count, cleared when drive stops
  always_comb begin
    next_oe_run = o_rst_pin_oe ? oe_run + {15'h0000, oe_run != 16'hFFFF} : 16'h0000;
  end
  always_ff @(posedge i_sys_clk) begin
    oe_run <= i_rst_n ? next_oe_run : 16'h0000;
  end
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  // Vector fetch takes two cycles, low address first
  sequence fetch_pair_s;
    (o_fetch_addr == 16'hFFFE) ##1 (o_fetch_en && o_fetch_addr == 16'hFFFF) ##1 !o_fetch_en;
  endsequence
  // Four cycles stands for the shortened minimum output pulse
  sequence pin_hold_s;
    o_rst_pin_oe [*4];
  endsequence
  ack_once_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held too long");
  ack_latency_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("ack missing");
  fetch_pair_a: assert property ($rose(o_fetch_en) |-> fetch_pair_s)
    else $error("vector fetch wrong");
  delay_len_a: assert property ($rose(o_fetch_en) |-> int'(oe_run) >= DLY_SHORT_P)
    else $error("delay too short");
  pin_low_a: assert property (o_rst_pin == 1'b0)
    else $error("pin driven high");
  wdg_pulse_a: assert property ($rose(i_wdg_underflow) |-> ##[1:4] pin_hold_s)
    else $error("watchdog pulse short");
  ext_pulse_a: assert property ($fell(i_rst_pin) |-> ##[1:4] pin_hold_s)
    else $error("pin pulse not stretched");
  supply_pin_a: assert property (i_supply_low && o_ana_ctl.det_en |-> ##[0:3] o_rst_pin_oe)
    else $error("pin free under low supply");
  irq_quiet_a: assert property ($rose(o_warn_irq) |-> !$past(o_cpu_reset))
    else $error("irq during reset");
  halt_freeze_a: assert property ($past(i_halt) |-> $stable(o_ana_ctl.src_sel))
    else $error("register moved in halt");
endmodule : rsm_checker
bind reset_sequence_and_supply_monitor rsm_checker #(.DLY_SHORT_P(DLY_SHORT_P)) u_chk (
  .i_sys_clk, .i_rst_n, .i_wb_cyc, .i_wb_stb, .o_wb_ack, .i_rst_pin, .o_rst_pin,
  .o_rst_pin_oe, .i_supply_low, .i_wdg_underflow, .i_halt, .o_cpu_reset, .o_fetch_en,
  .o_fetch_addr, .o_warn_irq, .o_ana_ctl
);
`default_nettype wire

// ===== bench/rst_partner.sv
// External reset circuitry sharing the open-drain reset pin
`timescale 1ns/100ps
`default_nettype none
module rst_partner (
  // Clock
  input wire logic i_sys_clk,
  // Pulse request and length
  input wire logic i_start,
  input wire logic [7:0] i_len,
  // Device drive
  input wire logic i_dut_oe,
  // Resolved pin
  output logic o_pin
);
  logic [7:0] left = 8'h00; // Low cycles remaining
  // Pulse counter; short pulses test the stretch
  always_ff @(posedge i_sys_clk) begin
    if (i_start) begin
      left <= i_len;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
  assign o_pin = !((left != 8'h00) || i_dut_oe);
endmodule : rst_partner
`default_nettype wire

// ===== bench/test_reset_sequence_and_supply_monitor.sv
// Self-checking bench for the reset sequencer and supply monitor
`timescale 1ns/100ps
`default_nettype none
module test_reset_sequence_and_supply_monitor;
  localparam int DS = 8; // Shortened counts
  localparam int DL = 16;
  localparam int MP = 4;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0; // Bus request
  logic [3:0] adr = 4'h0;
  logic [31:0] dat = 32'h0;
  logic wdg = 1'b0, halt = 1'b0, ack_irq = 1'b0, sup_low = 1'b0; // Causes
  logic vdd = 1'b0, sense = 1'b0, p_start = 1'b0;
  logic [7:0] p_len = 8'h00;
  logic [31:0] rdat;
  logic ack, pin, pin_drv, pin_oe, cpu_rst, fetch_en, irq;
  logic [15:0] fetch_addr;
  rsm_pkg::ana_ctl_t ana; // Analogue controls seen
  int err_count = 0;
  int total_checks = 0;
  int cnt;
  logic [7:0] q;
  logic [31:0] seed = 32'hF0CD5261;
  reset_sequence_and_supply_monitor #(.DLY_SHORT_P(DS), .DLY_LONG_P(DL), .MIN_PULSE_P(MP)) uut (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(4'h1), .i_wb_dat(dat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_rst_pin(pin), .o_rst_pin(pin_drv), .o_rst_pin_oe(pin_oe), .i_supply_low(sup_low),
    .i_warn_vdd(vdd), .i_warn_sense(sense), .i_wdg_underflow(wdg), .i_halt(halt),
    .i_warn_irq_ack(ack_irq), .o_cpu_reset(cpu_rst), .o_fetch_en(fetch_en),
    .o_fetch_addr(fetch_addr), .o_warn_irq(irq), .o_ana_ctl(ana)
  );
  rst_partner u_far (.i_sys_clk(i_sys_clk), .i_start(p_start), .i_len(p_len),
    .i_dut_oe(pin_oe), .o_pin(pin));
  // Free-running clock, 25 ns
  initial begin
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic summarize();
    if (err_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // Classic single cycle; entered just after a rising edge
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) begin
      err_count++;
      summarize();
    end
    @(posedge i_sys_clk);
  endtask : wb
  // Waits out a reset, counting pin drive cycles, then checks the fetch
  task automatic wait_run(output int n);
    int k;
    n = 0;
    for (k = 0; k < 20000 && fetch_en !== 1'b1; k++) begin
      @(posedge i_sys_clk);
      n += int'(pin_oe === 1'b1);
    end
    if (k >= 20000) begin
      err_count++;
      summarize();
    end
    chk("fetch lo", 32'h0000FFFE, {16'h0, fetch_addr});
    @(posedge i_sys_clk);
    chk("fetch hi", 32'h0000FFFF, {16'h0, fetch_addr});
    @(posedge i_sys_clk);
    chk("fetch end", 32'h0, {31'h0, fetch_en});
  endtask : wait_run
  // Checks irq against exp, then acknowledges and checks it cleared
  task automatic irq_step(input logic exp);
    repeat (4) @(posedge i_sys_clk);
    chk("irq", {31'h0, exp}, {31'h0, irq});
    ack_irq <= 1'b1;
    @(posedge i_sys_clk);
    ack_irq <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    chk("irq clear", 32'h0, {31'h0, irq});
  endtask : irq_step
  initial begin
    repeat (8) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    wait_run(cnt);
    chk("short delay", 32'h1, 32'(cnt >= DS));
    wb(1'b0, 4'h4, 8'h00);
    chk("option reset", 32'h02, {24'h0, q});
    wb(1'b0, 4'h8, 8'h00);
    chk("state run", 32'h08, {24'h0, q});
    wb(1'b0, 4'hC, 8'h00);
    chk("unmapped", 32'h00, {24'h0, q});
    wb(1'b1, 4'h4, 8'hFF);
    wb(1'b0, 4'h4, 8'h00);
    chk("option locked", 32'h02, {24'h0, q});
    wdg <= 1'b1;
    @(posedge i_sys_clk);
    wdg <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    wb(1'b1, 4'h4, 8'h5B);
    wait_run(cnt);
    wb(1'b0, 4'h4, 8'h00);
    chk("option long", 32'h5B, {24'h0, q});
    chk("analogue", 32'h66, {25'h0, ana});
    wb(1'b0, 4'h0, 8'h00);
    chk("wdg flag", 32'h01, {24'h0, q & 8'h11});
    seed = lfsr(seed);
    p_len <= 8'h02 + {7'h0, seed[0]};
    p_start <= 1'b1;
    @(posedge i_sys_clk);
    p_start <= 1'b0;
    wait_run(cnt);
    chk("stretch delay", 32'h1, 32'(cnt >= DL + MP));
    sup_low <= 1'b1;
    repeat (20) @(posedge i_sys_clk);
    chk("supply pin", 32'h1, {31'h0, pin_oe});
    chk("supply cpu", 32'h1, {31'h0, cpu_rst});
    sup_low <= 1'b0;
    wait_run(cnt);
    wb(1'b0, 4'h0, 8'h00);
    chk("supply flags", 32'h10, {24'h0, q & 8'h11});
    wb(1'b1, 4'h0, 8'h00);
    wb(1'b0, 4'h0, 8'h00);
    chk("flags cleared", 32'h00, {24'h0, q & 8'h11});
    wb(1'b1, 4'h0, 8'h40);
    vdd <= 1'b1;
    irq_step(1'b1);
    wb(1'b0, 4'h0, 8'h00);
    chk("warn flag", 32'h20, {24'h0, q & 8'h20});
    vdd <= 1'b0;
    irq_step(1'b1);
    wb(1'b1, 4'h0, 8'hC0);
    sense <= 1'b1;
    irq_step(1'b1);
    wb(1'b1, 4'h0, 8'h80);
    irq_step(1'b0);
    wb(1'b1, 4'h0, 8'hC0);
    irq_step(1'b1);
    seed = lfsr(seed);
    halt <= 1'b1;
    @(posedge i_sys_clk);
    wb(1'b1, 4'h0, seed[7:0]);
    wb(1'b0, 4'h0, 8'h00);
    chk("halt frozen", 32'hE0, {24'h0, q});
    halt <= 1'b0;
    summarize();
  end
endmodule : test_reset_sequence_and_supply_monitor
`default_nettype wire

// ===== pkg/rsm_pkg.sv
// Constants, types and register layout for the reset sequencer and supply monitor
package rsm_pkg;
  // Timing
  localparam int CLK_HZ = 40000000;
  localparam int MIN_PULSE_NS = 20000;
  localparam int MIN_PULSE_CYC = (MIN_PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int DLY_SHORT = 256;
  localparam int DLY_LONG = 4096;
  localparam int FETCH_CYC = 2;
  localparam int CNT_W = 13;
  // Reset vector locations
  localparam logic [15:0] VEC_LO_ADDR = 16'hFFFE;
  localparam logic [15:0] VEC_HI_ADDR = 16'hFFFF;
  // Register map (byte addresses)
  localparam logic [3:0] ADDR_SICS = 4'h0;
  localparam logic [3:0] ADDR_OPT = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;
  // Control/status field positions
  localparam int B_SRC = 7;
  localparam int B_IE = 6;
  localparam int B_WARN = 5;
  localparam int B_LVRF = 4;
  localparam int B_WDRF = 0;
  localparam logic [7:0] SICS_RESET = 8'h00;
  // Option field positions
  localparam int B_OPT_LONG = 0;
  localparam int B_OPT_DET = 1;
  localparam int B_OPT_THR = 2;
  localparam int B_OPT_RNG = 4;
  localparam int B_OPT_XTAL = 6;
  localparam logic [6:0] OPT_RESET = 7'h02;
  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_ACTIVE = 4'b0001,
    ST_DELAY = 4'b0010,
    ST_FETCH = 4'b0100,
    ST_RUN = 4'b1000
  } seq_state_t;
  // Analogue-facing controls
  typedef struct packed {
    logic det_en;
    logic [1:0] det_thr;
    logic [1:0] osc_range;
    logic osc_keep;
    logic src_sel;
  } ana_ctl_t;
endpackage : rsm_pkg

// ===== verilog/reset_sequence_and_supply_monitor.sv
// Reset sequencer, supply monitor and system integrity register behind Wishbone
//
// Implementation choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
module reset_sequence_and_supply_monitor #(
  parameter int DLY_SHORT_P = rsm_pkg::DLY_SHORT,
  parameter int DLY_LONG_P = rsm_pkg::DLY_LONG,
  parameter int MIN_PULSE_P = rsm_pkg::MIN_PULSE_CYC
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Open-drain reset pin
  input wire logic i_rst_pin,
  output logic o_rst_pin,
  output logic o_rst_pin_oe,
  // Analogue comparators
  input wire logic i_supply_low,
  input wire logic i_warn_vdd,
  input wire logic i_warn_sense,
  // Watchdog and CPU
  input wire logic i_wdg_underflow,
  input wire logic i_halt,
  input wire logic i_warn_irq_ack,
  output logic o_cpu_reset,
  output logic o_fetch_en,
  output logic [15:0] o_fetch_addr,
  output logic o_warn_irq,
  // Analogue controls
  output rsm_pkg::ana_ctl_t o_ana_ctl
);
  // Overview of the reset flow:
  // Any cause (pin, low supply, watchdog) forces the active phase at once.
  // The active phase lasts while a cause stands and the minimum pulse runs.
  // Then a fixed delay counts down, with the reset pin still pulled low.
  // Then two vector fetch cycles hand the start address to the core.
  // Only after that is the core released into normal running.
  // The pin is open-drain: we only ever pull it low, never drive it high.
  // The warning monitor sits beside the sequencer and shares its clock.
  // Its flag is a live copy of the selected comparator, not a latch.
  // Warning toggles raise no interrupt request while the core is held in reset.
  // Option bits act like straps and may only change while in reset.
  // Limitation: while we pull the pin ourselves, an outside pull is invisible;
  // it is seen as a held level as soon as our own drive stops.
  // Trade-off: counts are shared between delay and fetch to save flops.
  // All outputs but the constant pin level leave through registers, so no glitch reaches the pin.
  // Cause inputs other than the pin are taken as synchronous to the system clock.
  // Sequencer state
  // One-hot state and a shared down-counter for delay and fetch
  // The pulse counter runs apart so it can overlap the active phase
  rsm_pkg::seq_state_t state;
  rsm_pkg::seq_state_t next_state;
  logic [rsm_pkg::CNT_W-1:0] cnt;
  logic [rsm_pkg::CNT_W-1:0] next_cnt;
  logic [rsm_pkg::CNT_W-1:0] pulse;
  logic [rsm_pkg::CNT_W-1:0] next_pulse;
  logic cpu_reset;
  logic next_cpu_reset;
  logic fetch_en;
  logic next_fetch_en;
  logic [15:0] fetch_addr;
  logic [15:0] next_fetch_addr;
  logic pin_drive;
  logic next_pin_drive;
  // Register state
  logic [7:0] sics;
  logic [7:0] next_sics;
  logic [6:0] opt;
  logic [6:0] next_opt;
  logic irq;
  logic next_irq;
  logic ack;
  logic next_ack;
  logic [31:0] rdat;
  logic [31:0] next_rdat;
  rsm_pkg::ana_ctl_t ana;
  rsm_pkg::ana_ctl_t next_ana;
  // Cause qualification
  // Combinational helpers between the inputs and the next-state logic
  // None of these leaves the block without passing a register first
  logic det_on;
  logic lv_cause;
  logic pin_caught;
  logic warn_live;
  logic warn_tog;
  logic wr_hit;
  logic rd_hit;
  logic [rsm_pkg::CNT_W-1:0] dly_len;

  // Pin catch listens only while our own drive is off
  // Our drive holds the catcher clear, so the fall that we cause ourselves
  // never restarts the sequence and cannot lock it in the active phase.
  // A fall from outside while we are quiet sets the latch without a clock.
  // A pin still held low when our drive ends is caught as a level.
  // The caught request reaches the sequencer two clocks later.
  rsm_pin_catch u_pin (
    .i_sys_clk(i_sys_clk),
    .i_clr(pin_drive),
    .i_pin_n(i_rst_pin),
    .o_caught(pin_caught)
  );

  // Supply monitor qualification
  // With the detector off by option, its comparator is ignored entirely,
  // and the warning path goes quiet with it.
  // The thresholds themselves live in the analogue part.
  // detector only acts when enabled by option
  assign det_on = opt[rsm_pkg::B_OPT_DET];
  // comparator carries the hysteresis; static reset while it reports low
  assign lv_cause = det_on & i_supply_low;
  // option picks short or long delay
  assign dly_len = opt[rsm_pkg::B_OPT_LONG] ? rsm_pkg::CNT_W'(DLY_LONG_P - 1)
                                            : rsm_pkg::CNT_W'(DLY_SHORT_P - 1);
  // warning only with detector; select the monitored source
  assign warn_live = det_on & (sics[rsm_pkg::B_SRC] ? i_warn_sense : i_warn_vdd);

  // Edge detector on the live warning flag
  // Both directions count, so a rising supply also reports the end of a warning
  // A source switch that changes the level also shows as a toggle
  rsm_warn_edge u_edge (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_flag(warn_live),
    .o_toggle(warn_tog)
  );

  // Bus decode: single-cycle ack, dropped the cycle after
  // A request is taken on the edge where strobe stands and ack is low.
  // The ack term blocks a second hit on the acknowledged edge, so a master
  // that holds its request for the ack edge does not write twice.
  // Only byte lane 0 carries register bits.
  assign wr_hit = i_wb_cyc & i_wb_stb & i_wb_we & ~ack;
  assign rd_hit = i_wb_cyc & i_wb_stb & ~i_wb_we & ~ack;

  // Sequencer next state
  // Causes are checked after the state case so that they win in every state.
  // A cause in the delay or fetch phase starts the whole sequence again.
  // The minimum pulse is loaded only on entry from another state, so a cause
  // that stays high does not keep stretching the pulse for ever.
  // The delay starts only when no cause stands and the pulse has expired.
  // Fetch lasts two cycles: low vector byte first, then the high byte.
  // The pin drive follows the next state so it leaves with the delay phase.
  // Hazard: the fetch addresses are fixed; the core must not move them.
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_pulse = (pulse != '0) ? pulse - 1'b1 : pulse;
    next_cpu_reset = cpu_reset;
    next_fetch_en = 1'b0;
    next_fetch_addr = fetch_addr;
    unique case (state)
      rsm_pkg::ST_ACTIVE: begin
        next_cpu_reset = 1'b1;
        // hold active until all causes gone and pulse done
        if (!lv_cause && !pin_caught && !i_wdg_underflow && pulse == '0) begin
          next_state = rsm_pkg::ST_DELAY;
          next_cnt = dly_len;
        end
      end
      rsm_pkg::ST_DELAY: begin
        if (cnt == '0) begin
          next_state = rsm_pkg::ST_FETCH;
          next_cnt = rsm_pkg::CNT_W'(rsm_pkg::FETCH_CYC - 1);
          next_fetch_en = 1'b1;
          next_fetch_addr = rsm_pkg::VEC_LO_ADDR;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      rsm_pkg::ST_FETCH: begin
        if (cnt == '0) begin
          next_state = rsm_pkg::ST_RUN;
          next_cpu_reset = 1'b0;
        end else begin
          next_cnt = cnt - 1'b1;
          next_fetch_en = 1'b1;
          next_fetch_addr = rsm_pkg::VEC_HI_ADDR;
        end
      end
      rsm_pkg::ST_RUN: begin
        next_cpu_reset = 1'b0;
      end
      default: begin
        next_state = rsm_pkg::ST_ACTIVE;
      end
    endcase
    if (lv_cause || pin_caught || i_wdg_underflow) begin
      next_state = rsm_pkg::ST_ACTIVE;
      next_cpu_reset = 1'b1;
      next_fetch_en = 1'b0;
    end
    // pin or watchdog cause loads the minimum pulse
    if ((pin_caught || i_wdg_underflow) && state != rsm_pkg::ST_ACTIVE) begin
      next_pulse = rsm_pkg::CNT_W'(MIN_PULSE_P);
    end
    // drive pin through active and delay phases
    next_pin_drive = (next_state == rsm_pkg::ST_ACTIVE) || (next_state == rsm_pkg::ST_DELAY);
  end

  // Sequencer registers
  // Synchronous reset enters the active phase with the pin already pulled,
  // so other parts on the line see reset from the first clock on.
  // The counters start at zero and are loaded on the way into each phase.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state <= rsm_pkg::ST_ACTIVE;
      cnt <= '0;
      pulse <= '0;
      cpu_reset <= 1'b1;
      fetch_en <= 1'b0;
      fetch_addr <= rsm_pkg::VEC_LO_ADDR;
      pin_drive <= 1'b1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      pulse <= next_pulse;
      cpu_reset <= next_cpu_reset;
      fetch_en <= next_fetch_en;
      fetch_addr <= next_fetch_addr;
      pin_drive <= next_pin_drive;
    end
  end

  // Register file, interrupt and bus next values
  // Order matters below: later assignments override earlier ones.
  // Software writes come first, hardware sets and clears come after them,
  // so a hardware event in the same cycle as a software clear wins.
  // The interrupt set is placed after the service clear for the same reason.
  // Halt keeps the software side and the live flag frozen.
  // Read data is captured on the taken edge and held until the next read.
  // Unmapped addresses read as zero and ignore writes.
  always_comb begin
    next_sics = sics;
    next_opt = opt;
    next_irq = irq;
    next_ack = i_wb_cyc & i_wb_stb & ~ack;
    next_rdat = rdat;
    next_sics[rsm_pkg::B_WARN] = warn_live;
    // Options load only while the core is held in reset, like a strap
    if (wr_hit && i_wb_adr == rsm_pkg::ADDR_OPT && i_wb_sel[0] && cpu_reset) begin
      next_opt = i_wb_dat[6:0];
    end
    // halt freezes the software side of the register
    if (wr_hit && i_wb_adr == rsm_pkg::ADDR_SICS && i_wb_sel[0] && !i_halt) begin
      next_sics[rsm_pkg::B_SRC] = i_wb_dat[rsm_pkg::B_SRC];
      next_sics[rsm_pkg::B_IE] = i_wb_dat[rsm_pkg::B_IE];
      if (!i_wb_dat[rsm_pkg::B_WDRF]) next_sics[rsm_pkg::B_WDRF] = 1'b0;
      if (!i_wb_dat[rsm_pkg::B_LVRF]) next_sics[rsm_pkg::B_LVRF] = 1'b0;
      // enabling while flag set raises at once
      if (i_wb_dat[rsm_pkg::B_IE] && !sics[rsm_pkg::B_IE] && warn_live) next_irq = 1'b1;
    end
    if (i_halt) begin
      next_sics[rsm_pkg::B_WARN] = sics[rsm_pkg::B_WARN];
    end
    // service entry clears the pending request
    if (i_warn_irq_ack) next_irq = 1'b0;
    // toggle raises request only in the run phase, not in halt; set wins over ack
    if (warn_tog && sics[rsm_pkg::B_IE] && !cpu_reset && !i_halt) next_irq = 1'b1;
    // watchdog sets its flag, low supply clears it and wins over the watchdog set
    if (i_wdg_underflow) next_sics[rsm_pkg::B_WDRF] = 1'b1;
    if (lv_cause) begin
      next_sics[rsm_pkg::B_WDRF] = 1'b0;
      next_sics[rsm_pkg::B_LVRF] = 1'b1;
    end
    // Reset clears controls so software starts with interrupt off
    if (cpu_reset) begin
      next_sics[rsm_pkg::B_SRC] = 1'b0;
      next_sics[rsm_pkg::B_IE] = 1'b0;
    end
    if (rd_hit) begin
      unique case (i_wb_adr)
        rsm_pkg::ADDR_SICS: next_rdat = {24'h000000, sics};
        rsm_pkg::ADDR_OPT: next_rdat = {25'h0000000, opt};
        rsm_pkg::ADDR_STAT: next_rdat = {28'h0000000, state};
        default: next_rdat = 32'h00000000;
      endcase
    end
    // analogue controls from the option word; source select from the control register
    next_ana.det_en = det_on;
    next_ana.det_thr = opt[rsm_pkg::B_OPT_THR +: 2];
    next_ana.osc_range = opt[rsm_pkg::B_OPT_RNG +: 2];
    next_ana.osc_keep = opt[rsm_pkg::B_OPT_XTAL];
    next_ana.src_sel = sics[rsm_pkg::B_SRC];
  end

  // Register file registers
  // Reset leaves the detector enabled and the short delay selected,
  // and the analogue controls at zero until the first clock after reset.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      sics <= rsm_pkg::SICS_RESET;
      opt <= rsm_pkg::OPT_RESET;
      irq <= 1'b0;
      ack <= 1'b0;
      rdat <= 32'h00000000;
      ana <= '0;
    end else begin
      sics <= next_sics;
      opt <= next_opt;
      irq <= next_irq;
      ack <= next_ack;
      rdat <= next_rdat;
      ana <= next_ana;
    end
  end

  // Output stage
  // Every output comes from a register except the constant pin level.
  // The pad turns the enable into a pull to ground; the pull-up sits outside.
  // The pin level therefore never depends on a combinational path.
  // Hazard: driving the pin high would fight outside reset circuitry.
  // open-drain: drive low only, enable marks our pull
  assign o_rst_pin = 1'b0;
  assign o_rst_pin_oe = pin_drive;
  assign o_cpu_reset = cpu_reset;
  assign o_fetch_en = fetch_en;
  assign o_fetch_addr = fetch_addr;
  assign o_warn_irq = irq;
  assign o_wb_ack = ack;
  assign o_wb_dat = rdat;
  assign o_ana_ctl = ana;
endmodule : reset_sequence_and_supply_monitor
`default_nettype wire

// ===== verilog/rsm_pin_catch.sv
// Clockless catch of a low reset pin, released into the clock domain
`timescale 1ns/100ps
`default_nettype none
module rsm_pin_catch (
  // Clock and clear
  input wire logic i_sys_clk,
  input wire logic i_clr,
  // Pin level
  input wire logic i_pin_n,
  // Caught request
  output logic o_caught
);
  logic latch_q;
  logic sync1;
  logic sync2;
  logic next_sync1;
  logic next_sync2;

  // clockless pin catch: the pin's fall sets the latch with no clock running
  // Clear stays high while this device drives the pin, so our own pull is never caught
  always_ff @(negedge i_pin_n or posedge i_clr) begin
    if (i_clr) begin
      latch_q <= 1'b0;
    end else begin
      latch_q <= 1'b1;
    end
  end

  // First stage also sees a pin held low by others once our own drive is off
  always_comb begin
    next_sync1 = latch_q | (~i_pin_n & ~i_clr);
    // Second stage reads only the first
    next_sync2 = sync1;
  end

  // Two-stage synchroniser into the clock domain
  always_ff @(posedge i_sys_clk) begin
    sync1 <= next_sync1;
    sync2 <= next_sync2;
  end

  // Level also caught while clock runs, so a held pin keeps asking
  assign o_caught = sync2;
endmodule : rsm_pin_catch
`default_nettype wire

// ===== verilog/rsm_warn_edge.sv
// Warning flag edge detector producing a toggle event
`timescale 1ns/100ps
`default_nettype none
module rsm_warn_edge (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Flag level
  input wire logic i_flag,
  // Toggle pulse
  output logic o_toggle
);
  logic prev;
  logic next_prev;

  // Track the last value
  always_comb begin
    next_prev = i_flag;
  end

  // Register the previous level
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      prev <= 1'b0;
    end else begin
      prev <= next_prev;
    end
  end

  assign o_toggle = prev ^ i_flag;
endmodule : rsm_warn_edge
`default_nettype wire
